// >>> verilog/tmr_pkg.sv
package tmr_pkg;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE    = 8'h89;
  localparam logic [7:0] ADDR_T0_LO   = 8'h8A;
  localparam logic [7:0] ADDR_T1_LO   = 8'h8B;
  localparam logic [7:0] ADDR_T0_HI   = 8'h8C;
  localparam logic [7:0] ADDR_T1_HI   = 8'h8D;
  localparam logic [7:0] ADDR_SCALE   = 8'h8E;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'hA8;
  localparam logic [7:0] ADDR_EXT_CFG = 8'hE4;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int OVF1_POS   = 7;
  localparam int RUN1_POS   = 6;
  localparam int OVF0_POS   = 5;
  localparam int RUN0_POS   = 4;
  localparam int XFLAG1_POS = 3;
  localparam int XTYPE1_POS = 2;
  localparam int XFLAG0_POS = 1;
  localparam int XTYPE0_POS = 0;
  localparam int CT_BIT   = 2;
  localparam int GATE_BIT = 3;
  localparam int T1_FIELD = 4;
  localparam int T0_CLKSEL = 2;
  localparam int T1_CLKSEL = 3;
  localparam int EN0_POS = 1;
  localparam int EN1_POS = 3;
  localparam int PL0 = 3;
  localparam int PL1 = 7;
  localparam logic [7:0] SCALE_BASE = 8'h04;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } mode_type;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } step_type;
endpackage

// >>> verilog/timer_counter_pair.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - each timer holds 16 bits, read and written as low and high bytes
// - each timer has its own two-bit mode field in the mode register
// - mode 0 counts 13 bits: high byte plus low-byte bits 4..0
// - 13-bit wrap from all ones sets overflow flag, may interrupt
// - count select high: count falling edges of the timer's count pin
// - count select low: count system clock or scaled clock per clock select
// - count only when run set and gate clear or ext input active
// - mode 3: timer 0 low byte is 8-bit counter with timer 0 controls
// - mode 3: timer 0 high byte counts clock, run by timer 1, sets its flag
// - timer 0 in mode 3: timer 1 no pin, no flag, overflow still exported
// - timer 0 in mode 3: timer 1 runs in modes 0-2, stops in mode 3
// - control register bit layout as listed, all zero at reset
// - overflow flags set by hardware, cleared by software or vectoring
// - ext flags set per type; vectoring clears them only when edge-triggered
// - type bit 0 level, 1 edge; polarity bit sets active level
// - timer interrupts reach the processor only when individually enabled
module timer_counter_pair (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire tmr_pkg::sfr_req_type sfr,
  output logic [7:0]                sfr_rdata,
  input  wire logic                 counter0_input_pin,
  input  wire logic                 counter1_input_pin,
  input  wire logic                 ext_irq0_input,
  input  wire logic                 ext_irq1_input,
  input  wire logic                 ack_timer0,
  input  wire logic                 ack_timer1,
  input  wire logic                 ack_ext0,
  input  wire logic                 ack_ext1,
  output logic                      irq_timer0,
  output logic                      irq_timer1,
  output logic                      irq_ext0,
  output logic                      irq_ext1,
  output logic                      timer1_overflow_out
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_pipe_reg;
  wire        rst_n = rst_pipe_reg[1];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rst_pipe_reg <= 2'b00;
    else rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire  [3:0] pins = {ext_irq1_input, ext_irq0_input, counter1_input_pin, counter0_input_pin};
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          // idle high: no false edge or active level right after reset
          sync1_reg[i] <= 1'b1;
          sync2_reg[i] <= 1'b1;
          prev_reg[i]  <= 1'b1;
        end else begin
          sync1_reg[i] <= pins[i];
          sync2_reg[i] <= sync1_reg[i];
          prev_reg[i]  <= sync2_reg[i];
        end
      end
    end
  endgenerate
  wire [1:0] pin_fall = prev_reg[1:0] & ~sync2_reg[1:0];

  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  logic [7:0] control_reg;
  logic [7:0] mode_reg;
  logic [7:0] scale_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] ext_cfg_reg;
  logic [7:0] t0_lo_reg;
  logic [7:0] t0_hi_reg;
  logic [7:0] t1_lo_reg;
  logic [7:0] t1_hi_reg;
  logic [7:0] prescale_reg;
  logic [7:0] rdata_reg;
  logic       ovf_out_reg;

  function automatic logic hit(input tmr_pkg::sfr_req_type r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  wire wr_ctl = hit(sfr, tmr_pkg::ADDR_CONTROL);
  wire wr_t0l = hit(sfr, tmr_pkg::ADDR_T0_LO);
  wire wr_t0h = hit(sfr, tmr_pkg::ADDR_T0_HI);
  wire wr_t1l = hit(sfr, tmr_pkg::ADDR_T1_LO);
  wire wr_t1h = hit(sfr, tmr_pkg::ADDR_T1_HI);

  tmr_pkg::mode_type m0;
  tmr_pkg::mode_type m1;
  assign m0 = tmr_pkg::mode_type'(mode_reg[1:0]);
  assign m1 = tmr_pkg::mode_type'(mode_reg[tmr_pkg::T1_FIELD +: 2]);
  wire split = (m0 == tmr_pkg::MODE_SPLIT);
  wire ct0   = mode_reg[tmr_pkg::CT_BIT];
  wire timer0_gate_enable = mode_reg[tmr_pkg::GATE_BIT];
  wire ct1   = mode_reg[tmr_pkg::T1_FIELD + tmr_pkg::CT_BIT];
  wire gate1 = mode_reg[tmr_pkg::T1_FIELD + tmr_pkg::GATE_BIT];

  // ----------------------------------------
  // external inputs: polarity, gating, flags
  // ----------------------------------------
  wire [1:0] pol      = {ext_cfg_reg[tmr_pkg::PL1], ext_cfg_reg[tmr_pkg::PL0]};
  wire [1:0] act      = ~(sync2_reg[3:2] ^ pol);
  wire [1:0] prev_act = ~(prev_reg[3:2] ^ pol);
  wire [1:0] itype    = {control_reg[tmr_pkg::XTYPE1_POS], control_reg[tmr_pkg::XTYPE0_POS]};
  // edge mode catches the move into the active level, level mode holds it
  wire [1:0] ext_set  = (itype & act & ~prev_act) | (~itype & act);

  // ----------------------------------------
  // count enables
  // ----------------------------------------
  wire [7:0] scale_mask = (tmr_pkg::SCALE_BASE << {scale_reg[1:0], 1'b0}) - 8'h01;
  wire       scale_tick = (prescale_reg & scale_mask) == scale_mask;
  wire       clk_tick0  = scale_reg[tmr_pkg::T0_CLKSEL] ? scale_tick : 1'b1;
  wire       clk_tick1  = scale_reg[tmr_pkg::T1_CLKSEL] ? scale_tick : 1'b1;
  wire       run_bit0   = control_reg[tmr_pkg::RUN0_POS];
  wire       run_bit1   = control_reg[tmr_pkg::RUN1_POS];
  wire       run0       = run_bit0 && (!timer0_gate_enable || act[0]);
  wire       run1       = run_bit1 && (!gate1 || act[1]);
  wire       inc0       = run0 && (ct0 ? pin_fall[0] : clk_tick0);
  // split: timer 1 ignores its run bit and pin, mode 3 is its only stop
  wire       inc1       = (m1 != tmr_pkg::MODE_SPLIT) &&
                          (split ? clk_tick1 :
                           run1 && (ct1 ? pin_fall[1] : clk_tick1));
  wire       inc_hi0    = split && run_bit1 && clk_tick0;

  // ----------------------------------------
  // counter step
  // ----------------------------------------
  function automatic tmr_pkg::step_type step(input tmr_pkg::mode_type m,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi,
                                             input logic       inc);
    tmr_pkg::step_type s;
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    s   = '{lo: lo, hi: hi, ovf: 1'b0};
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    c16 = {1'b0, hi, lo} + 17'h00001;
    c8  = {1'b0, lo} + 9'h001;
    if (inc) begin
      unique case (m)
        tmr_pkg::MODE_13BIT: begin
          // upper low-byte bits are left as they were
          s.hi  = c13[12:5];
          s.lo  = {lo[7:5], c13[4:0]};
          s.ovf = c13[13];
        end
        tmr_pkg::MODE_16BIT: begin
          s.hi  = c16[15:8];
          s.lo  = c16[7:0];
          s.ovf = c16[16];
        end
        tmr_pkg::MODE_RELOAD: begin
          s.lo  = c8[8] ? hi : c8[7:0];
          s.ovf = c8[8];
        end
        tmr_pkg::MODE_SPLIT: begin
          s.lo  = c8[7:0];
          s.ovf = c8[8];
        end
      endcase
    end
    return s;
  endfunction

  tmr_pkg::step_type t0s;
  tmr_pkg::step_type t1s;
  assign t0s = step(m0, t0_lo_reg, t0_hi_reg, inc0);
  assign t1s = step(m1, t1_lo_reg, t1_hi_reg, inc1);
  wire [8:0] hi_split = {1'b0, t0_hi_reg} + {8'h00, inc_hi0};

  // software writes win over counting for the data bytes
  wire [7:0] t0_lo_next = wr_t0l ? sfr.wdata : t0s.lo;
  wire [7:0] t0_hi_next = wr_t0h ? sfr.wdata : (split ? hi_split[7:0] : t0s.hi);
  wire [7:0] t1_lo_next = wr_t1l ? sfr.wdata : t1s.lo;
  wire [7:0] t1_hi_next = wr_t1h ? sfr.wdata : t1s.hi;

  // ----------------------------------------
  // control flags
  // ----------------------------------------
  wire tf0_set = t0s.ovf;
  wire tf1_set = split ? hi_split[8] : t1s.ovf;
  wire [7:0] ctl_base = wr_ctl ? sfr.wdata : control_reg;
  wire [7:0] ctl_clr  = {ack_timer1, 1'b0, ack_timer0, 1'b0,
                         ack_ext1 & itype[1], 1'b0, ack_ext0 & itype[0], 1'b0};
  wire [7:0] ctl_set  = {tf1_set, 1'b0, tf0_set, 1'b0, ext_set[1], 1'b0, ext_set[0], 1'b0};
  // hardware set beats any clear in the same cycle
  wire [7:0] control_next = (ctl_base & ~ctl_clr) | ctl_set;

  wire [7:0] rd_mux =
    (sfr.addr == tmr_pkg::ADDR_CONTROL) ? control_reg :
    (sfr.addr == tmr_pkg::ADDR_MODE)    ? mode_reg :
    (sfr.addr == tmr_pkg::ADDR_T0_LO)   ? t0_lo_reg :
    (sfr.addr == tmr_pkg::ADDR_T1_LO)   ? t1_lo_reg :
    (sfr.addr == tmr_pkg::ADDR_T0_HI)   ? t0_hi_reg :
    (sfr.addr == tmr_pkg::ADDR_T1_HI)   ? t1_hi_reg :
    (sfr.addr == tmr_pkg::ADDR_SCALE)   ? scale_reg :
    (sfr.addr == tmr_pkg::ADDR_IRQ_EN)  ? irq_en_reg :
    (sfr.addr == tmr_pkg::ADDR_EXT_CFG) ? ext_cfg_reg : tmr_pkg::RESET_BYTE;

  // ----------------------------------------
  // state update
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg  <= tmr_pkg::RESET_BYTE;
      mode_reg     <= tmr_pkg::RESET_BYTE;
      scale_reg    <= tmr_pkg::RESET_BYTE;
      irq_en_reg   <= tmr_pkg::RESET_BYTE;
      ext_cfg_reg  <= tmr_pkg::RESET_BYTE;
      t0_lo_reg    <= tmr_pkg::RESET_BYTE;
      t0_hi_reg    <= tmr_pkg::RESET_BYTE;
      t1_lo_reg    <= tmr_pkg::RESET_BYTE;
      t1_hi_reg    <= tmr_pkg::RESET_BYTE;
      prescale_reg <= tmr_pkg::RESET_BYTE;
      rdata_reg    <= tmr_pkg::RESET_BYTE;
      ovf_out_reg  <= 1'b0;
    end else begin
      control_reg  <= control_next;
      if (hit(sfr, tmr_pkg::ADDR_MODE)) mode_reg <= sfr.wdata;
      if (hit(sfr, tmr_pkg::ADDR_SCALE)) scale_reg <= sfr.wdata;
      if (hit(sfr, tmr_pkg::ADDR_IRQ_EN)) irq_en_reg <= sfr.wdata;
      if (hit(sfr, tmr_pkg::ADDR_EXT_CFG)) ext_cfg_reg <= sfr.wdata;
      t0_lo_reg    <= t0_lo_next;
      t0_hi_reg    <= t0_hi_next;
      t1_lo_reg    <= t1_lo_next;
      t1_hi_reg    <= t1_hi_next;
      prescale_reg <= prescale_reg + 8'h01;
      if (sfr.rd) rdata_reg <= rd_mux;
      ovf_out_reg  <= t1s.ovf;
    end
  end

  assign sfr_rdata           = rdata_reg;
  assign timer1_overflow_out = ovf_out_reg;
  assign irq_timer0 = control_reg[tmr_pkg::OVF0_POS] && irq_en_reg[tmr_pkg::EN0_POS];
  assign irq_timer1 = control_reg[tmr_pkg::OVF1_POS] && irq_en_reg[tmr_pkg::EN1_POS];
  assign irq_ext0   = control_reg[tmr_pkg::XFLAG0_POS];
  assign irq_ext1   = control_reg[tmr_pkg::XFLAG1_POS];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire t0_wr = wr_t0l || wr_t0h;

  a_wrap13_flag: assert property (
    m0 == tmr_pkg::MODE_13BIT && inc0 && t0_hi_reg == 8'hFF && t0_lo_reg[4:0] == 5'h1F
    && !t0_wr |=> t0_hi_reg == 8'h00 && t0_lo_reg[4:0] == 5'h00
    && control_reg[tmr_pkg::OVF0_POS])
    else $error("13-bit wrap did not clear count and set flag");
  a_reload_low: assert property (
    m0 == tmr_pkg::MODE_RELOAD && inc0 && t0_lo_reg == 8'hFF && !t0_wr
    |=> t0_lo_reg == $past(t0_hi_reg) && control_reg[tmr_pkg::OVF0_POS])
    else $error("reload mode did not reload low byte");
  a_run_gate_hold: assert property (
    (!run_bit0 || (timer0_gate_enable && !act[0])) && !t0_wr && !split |=> $stable({t0_hi_reg, t0_lo_reg}))
    else $error("timer 0 counted while stopped");
  a_pin_edge_only: assert property (
    ct0 && run0 && !pin_fall[0] && !t0_wr |=> $stable(t0_lo_reg))
    else $error("counter mode moved without a falling edge");
  a_split_high_flag: assert property (
    split && run_bit1 && clk_tick0 && t0_hi_reg == 8'hFF && !wr_t0h
    |=> t0_hi_reg == 8'h00 && control_reg[tmr_pkg::OVF1_POS])
    else $error("split high byte overflow missed timer 1 flag");
  a_split_t1_quiet: assert property (
    split && !inc_hi0 && !wr_ctl |=> !$rose(control_reg[tmr_pkg::OVF1_POS]))
    else $error("timer 1 set its flag while timer 0 split");
  a_split_t1_stop: assert property (
    split && m1 == tmr_pkg::MODE_SPLIT && !wr_t1l && !wr_t1h
    |=> $stable({t1_hi_reg, t1_lo_reg}))
    else $error("timer 1 ran in mode 3");
  a_ack_clears_tf: assert property (
    ack_timer0 && !tf0_set && !wr_ctl |=> !control_reg[tmr_pkg::OVF0_POS])
    else $error("vectoring did not clear timer 0 flag");
  a_level_keeps_flag: assert property (
    !itype[0] && control_reg[tmr_pkg::XFLAG0_POS] && ack_ext0 && !wr_ctl
    |=> control_reg[tmr_pkg::XFLAG0_POS])
    else $error("level flag cleared by vectoring");
  a_irq_masked: assert property (
    !irq_en_reg[tmr_pkg::EN1_POS] |-> !irq_timer1)
    else $error("timer 1 interrupt passed while disabled");
endmodule
`default_nettype wire

// >>> tb/pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
  input  wire logic       clk,
  output var  logic [1:0] count_pin,
  output var  logic [1:0] ext_in
);
  initial begin
    count_pin = 2'b11;
    // inactive for the active-low polarity that reset selects
    ext_in    = 2'b11;
  end
  // ----------------------------------------
  // pin waveforms
  // ----------------------------------------
  // levels held three clocks so two sync flops never miss an edge
  task automatic falls(input int ch, input int n);
    repeat (n) begin
      @(posedge clk) #1 count_pin[ch] = 1'b0;
      repeat (3) @(posedge clk);
      #1 count_pin[ch] = 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic set_ext(input int ch, input logic v);
    @(posedge clk) #1 ext_in[ch] = v;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 clk;
  logic                 rstn;
  tmr_pkg::sfr_req_type sfr;
  logic [7:0]           rdata, d, a, hi, lo;
  logic [1:0]           cpin, xin, ack_t, ack_e, irq_t, irq_e;
  logic                 ovf_out;
  logic [15:0]          r;
  logic [15:0]          lfsr = 16'h325C;
  int fails = 0, n_compared = 0, ovf_pulses = 0;
  int ch, m, k, n, en, cnt, ovf, elo, ehi, typ, s, p0;

  pin_driver pins (.clk(clk), .count_pin(cpin), .ext_in(xin));
  timer_counter_pair uut (.clk(clk), .rstn(rstn), .sfr(sfr), .sfr_rdata(rdata),
    .counter0_input_pin(cpin[0]), .counter1_input_pin(cpin[1]),
    .ext_irq0_input(xin[0]), .ext_irq1_input(xin[1]),
    .ack_timer0(ack_t[0]), .ack_timer1(ack_t[1]), .ack_ext0(ack_e[0]), .ack_ext1(ack_e[1]),
    .irq_timer0(irq_t[0]), .irq_timer1(irq_t[1]), .irq_ext0(irq_e[0]), .irq_ext1(irq_e[1]),
    .timer1_overflow_out(ovf_out));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (ovf_out === 1'b1) ovf_pulses <= ovf_pulses + 1;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] nxt();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk) #1 sfr = '{1'b1, 1'b0, ad, wd};
    @(posedge clk) #1 sfr.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] q);
    @(posedge clk) #1 sfr = '{1'b0, 1'b1, ad, 8'h00};
    @(posedge clk) #1 sfr.rd = 1'b0;
    q = rdata;
  endtask
  task automatic pulse_ack(input int kind, input int c);
    @(posedge clk) #1;
    if (kind == 0) ack_t[c] = 1'b1;
    else ack_e[c] = 1'b1;
    @(posedge clk) #1 ack_t = 2'b00;
    ack_e = 2'b00;
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(4 * 20000);
    fails++;
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    sfr = '0;
    ack_t = 2'b00;
    ack_e = 2'b00;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    rd(tmr_pkg::ADDR_CONTROL, d); check(d, tmr_pkg::RESET_BYTE);
    rd(8'h90, d); check(d, 8'h00);
    // counting by pin edges in modes 0..2, random start and edge count
    for (ch = 0; ch < 2; ch++) for (m = 0; m < 3; m++) begin
      r = nxt();
      n = int'(r[1:0]) + 1;
      en = r[4];
      hi = (m == 2) ? r[15:8] : 8'hFF;
      lo = 8'hFC | r[9:8];
      wr(tmr_pkg::ADDR_MODE, 8'((4 | m) << (4 * ch)));
      wr(tmr_pkg::ADDR_IRQ_EN, en ? 8'(1 << (tmr_pkg::EN0_POS + 2 * ch)) : 8'h00);
      wr(tmr_pkg::ADDR_T0_LO + 8'(ch), lo);
      wr(tmr_pkg::ADDR_T0_HI + 8'(ch), hi);
      wr(tmr_pkg::ADDR_CONTROL, 8'(1 << (tmr_pkg::RUN0_POS + 2 * ch)));
      pins.falls(ch, n);
      repeat (6) @(posedge clk);
      cnt = (m == 0) ? {hi, lo[4:0]} : {hi, lo};
      elo = lo;
      ovf = 0;
      for (k = 0; k < n; k++) begin
        if (m != 2) cnt++;
        else if (elo == 255) begin
          elo = hi;
          ovf = 1;
        end else elo++;
      end
      ehi = hi;
      if (m == 0) begin
        ovf = cnt > 'h1FFF;
        ehi = (cnt >> 5) & 'hFF;
        elo = cnt & 'h1F;
      end
      if (m == 1) begin
        ovf = cnt > 'hFFFF;
        ehi = (cnt >> 8) & 'hFF;
        elo = cnt & 'hFF;
      end
      rd(tmr_pkg::ADDR_CONTROL, d);
      check({7'h00, d[tmr_pkg::OVF0_POS + 2 * ch]}, 8'(ovf));
      check({7'h00, irq_t[ch]}, 8'(ovf & en));
      rd(tmr_pkg::ADDR_T0_LO + 8'(ch), d);
      check((m == 0) ? (d & 8'h1F) : d, 8'(elo));
      rd(tmr_pkg::ADDR_T0_HI + 8'(ch), d); check(d, 8'(ehi));
      pulse_ack(0, ch);
      rd(tmr_pkg::ADDR_CONTROL, d);
      check({7'h00, d[tmr_pkg::OVF0_POS + 2 * ch]}, 8'h00);
      wr(tmr_pkg::ADDR_CONTROL, 8'h00);
    end
    // gate: edges count only while the gate input is active
    wr(tmr_pkg::ADDR_EXT_CFG, 8'h08);
    pins.set_ext(0, 1'b0);
    wr(tmr_pkg::ADDR_MODE, 8'h0D);
    wr(tmr_pkg::ADDR_T0_LO, 8'h00);
    wr(tmr_pkg::ADDR_T0_HI, 8'h00);
    wr(tmr_pkg::ADDR_CONTROL, 8'h10);
    pins.falls(0, 2);
    pins.set_ext(0, 1'b1);
    pins.falls(0, 3);
    wr(tmr_pkg::ADDR_CONTROL, 8'h00);
    pins.falls(0, 1);
    repeat (6) @(posedge clk);
    rd(tmr_pkg::ADDR_T0_LO, d); check(d, 8'h03);
    // external flags, level and edge, both polarities
    for (ch = 0; ch < 2; ch++) for (typ = 0; typ < 2; typ++) begin
      pins.set_ext(ch, !typ);
      repeat (5) @(posedge clk);
      wr(tmr_pkg::ADDR_EXT_CFG, typ ? (ch ? 8'h80 : 8'h08) : 8'h00);
      wr(tmr_pkg::ADDR_CONTROL, 8'(typ << (2 * ch)));
      repeat (5) @(posedge clk);
      check({7'h00, irq_e[ch]}, 8'h00);
      pins.set_ext(ch, typ);
      repeat (6) @(posedge clk);
      check({7'h00, irq_e[ch]}, 8'h01);
      pins.set_ext(ch, !typ);
      repeat (6) @(posedge clk);
      pulse_ack(1, ch);
      repeat (2) @(posedge clk);
      check({7'h00, irq_e[ch]}, 8'(!typ));
      wr(tmr_pkg::ADDR_CONTROL, 8'h00);
      repeat (2) @(posedge clk);
      check({7'h00, irq_e[ch]}, 8'h00);
    end
    // clock sources: system clock, then divide-by-4 scaled tick
    for (s = 0; s < 2; s++) begin
      wr(tmr_pkg::ADDR_MODE, 8'h01);
      wr(tmr_pkg::ADDR_SCALE, s ? tmr_pkg::SCALE_BASE : 8'h00);
      wr(tmr_pkg::ADDR_T0_LO, 8'h00);
      wr(tmr_pkg::ADDR_T0_HI, 8'h00);
      wr(tmr_pkg::ADDR_CONTROL, 8'h10);
      repeat (64) @(posedge clk);
      wr(tmr_pkg::ADDR_CONTROL, 8'h00);
      rd(tmr_pkg::ADDR_T0_LO, d);
      ehi = s ? 16 : 64;
      check({7'h00, d >= ehi - 3 && d <= ehi + 3}, 8'h01);
    end
    // split mode
    wr(tmr_pkg::ADDR_SCALE, 8'h00);
    wr(tmr_pkg::ADDR_MODE, 8'h13);
    wr(tmr_pkg::ADDR_T0_LO, 8'h00);
    wr(tmr_pkg::ADDR_T0_HI, 8'hFE);
    wr(tmr_pkg::ADDR_IRQ_EN, 8'h08);
    wr(tmr_pkg::ADDR_CONTROL, 8'h40);
    repeat (20) @(posedge clk);
    rd(tmr_pkg::ADDR_CONTROL, d); check(d & 8'hA0, 8'h80);
    check({7'h00, irq_t[1]}, 8'h01);
    rd(tmr_pkg::ADDR_T0_LO, d); check(d, 8'h00);
    rd(tmr_pkg::ADDR_T1_LO, a);
    rd(tmr_pkg::ADDR_T1_LO, d); check({7'h00, a != d}, 8'h01);
    wr(tmr_pkg::ADDR_MODE, 8'h23);
    wr(tmr_pkg::ADDR_CONTROL, 8'h00);
    p0 = ovf_pulses;
    repeat (300) @(posedge clk);
    rd(tmr_pkg::ADDR_CONTROL, d); check(d & 8'h80, 8'h00);
    check({7'h00, ovf_pulses > p0}, 8'h01);
    wr(tmr_pkg::ADDR_MODE, 8'h33);
    rd(tmr_pkg::ADDR_T1_LO, a);
    rd(tmr_pkg::ADDR_T1_LO, d); check(d, a);
    final_report();
  end
endmodule
`default_nettype wire
